// ### rtl/nts_defs.svh
// offsets, field positions and reset values of the test status register bank
// assumes inclusion by its bare name from the package; the bank module uses its macros without including it
`ifndef NTS_DEFS_SVH
`define NTS_DEFS_SVH

`define NTS_OFS_FREE_COUNT 16'h0124
`define NTS_OFS_SLOW_FLAG 16'h0128
`define NTS_OFS_FAIL_LOW 16'h0140
`define NTS_OFS_FAIL_HIGH 16'h0144
`define NTS_OFS_COUNT_LOW 16'h0148
`define NTS_OFS_COUNT_HIGH 16'h014c
`define NTS_OFS_EXP_BASE 16'h0180
`define NTS_OFS_RDP_BASE 16'h01c0
`define NTS_OFS_STS_FIRST 16'h0100
`define NTS_OFS_STS_LAST 16'h01ff
`define NTS_OFS_SUBM_BASE 16'h0200
`define NTS_OFS_CPL_BASE 16'h0300
`define NTS_OFS_VERSION 16'h0800
`define NTS_OFS_IRQ_STATUS 16'h0900
`define NTS_OFS_IRQ_MASK 16'h0904
`define NTS_OFS_IDC_BASE 16'h2000
`define NTS_OFS_IDN_BASE 16'h3000
`define NTS_OFS_CRAM_BASE 16'h4000
`define NTS_OFS_CRAM_LAST 16'h5fff
`define NTS_IRQ_BIT_SLOW 0
`define NTS_IRQ_BIT_FAIL 1
`define NTS_IRQ_BIT_CPL 2
`define NTS_IRQ_RESET 3'h0
`define NTS_MASK_RESET 3'h0

`endif

// ### rtl/nts_pkg.sv
// types shared by the test status register bank and its surroundings
// assumes nts_defs.svh is on the include path
package nts_pkg;
  `include "nts_defs.svh"

  // address regions seen by the bus slave
  typedef enum logic [4:0] {
    NTS_REG_NONE = 5'h00,
    NTS_REG_FREE = 5'h01,
    NTS_REG_SLOW = 5'h02,
    NTS_REG_FAILL = 5'h03,
    NTS_REG_FAILH = 5'h04,
    NTS_REG_CNTL = 5'h05,
    NTS_REG_CNTH = 5'h06,
    NTS_REG_EXP = 5'h07,
    NTS_REG_RDP = 5'h08,
    NTS_REG_STSRSV = 5'h09,
    NTS_REG_SUBM = 5'h0a,
    NTS_REG_CPL = 5'h0b,
    NTS_REG_VER = 5'h0c,
    NTS_REG_ISTS = 5'h0d,
    NTS_REG_IMSK = 5'h0e,
    NTS_REG_IDC = 5'h0f,
    NTS_REG_IDN = 5'h10,
    NTS_REG_CRAM = 5'h11
  } nts_region_e;

  // first miscompare report from the pattern checker
  typedef struct packed {
    logic [56:0] addr;
    logic [127:0] expected;
    logic [127:0] readback;
  } nts_fail_s;

  // identify data write from the core, sel 0 controller, 1 namespace
  typedef struct packed {
    logic we;
    logic sel;
    logic [9:0] addr;
    logic [31:0] data;
  } nts_iden_wr_s;

  // custom command ram access from the core
  typedef struct packed {
    logic we;
    logic [10:0] addr;
    logic [31:0] data;
  } nts_ram_req_s;
endpackage

// ### rtl/nts_regs.sv
// test status register bank: apb slave over status, custom queue,
// identify and custom ram windows of the nvme test demo
// assumes generator and core logic run on CLOCK_I; apb master keeps the protocol
//
// Functional notes
// - free count field mirrors generator free space
// - slow flag set on late address supply
// - write or read command clears slow flag
// - first fail byte address, 57 bits split
// - 45-bit completed count split low/high
// - expected 128-bit pattern, low word first
// - read-back 128-bit data, low word first
// - status range read-only, writes change nothing
// - sixteen write-only submission dwords feed core
// - four completion dwords read from core
// - version register returns core version unchanged
// - 4 KB identify controller read window
// - 4 KB identify namespace read window
// - 8 KB read/write custom command ram
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`default_nettype none

module nts_regs
  import nts_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  input wire logic [9:0] GEN_FREE_COUNT_I,
  input wire logic GEN_SLOW_I,
  input wire logic TEST_START_I,
  input wire logic GEN_FAIL_I,
  input wire nts_fail_s GEN_FAIL_INFO_I,
  input wire logic [44:0] GEN_COMPLETED_COUNT_I,
  input wire logic [31:0] CORE_VERSION_I,
  input wire logic [127:0] CPL_ENTRY_I,
  input wire logic CPL_VALID_I,
  output logic [511:0] SUBM_ENTRY_O,
  input wire nts_iden_wr_s IDEN_WR_I,
  input wire nts_ram_req_s CRAM_REQ_I,
  output logic [31:0] CRAM_RDATA_O
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // map a byte address onto a region of the bank
  function automatic nts_region_e decode(input logic [15:0] a);
    nts_region_e r;
    r = NTS_REG_NONE;
    if (a[1:0] != 2'h0) begin
      r = NTS_REG_NONE;
    end else if (a == `NTS_OFS_FREE_COUNT) begin
      r = NTS_REG_FREE;
    end else if (a == `NTS_OFS_SLOW_FLAG) begin
      r = NTS_REG_SLOW;
    end else if (a == `NTS_OFS_FAIL_LOW) begin
      r = NTS_REG_FAILL;
    end else if (a == `NTS_OFS_FAIL_HIGH) begin
      r = NTS_REG_FAILH;
    end else if (a == `NTS_OFS_COUNT_LOW) begin
      r = NTS_REG_CNTL;
    end else if (a == `NTS_OFS_COUNT_HIGH) begin
      r = NTS_REG_CNTH;
    end else if (a[15:4] == `NTS_OFS_EXP_BASE >> 4) begin
      r = NTS_REG_EXP;
    end else if (a[15:4] == `NTS_OFS_RDP_BASE >> 4) begin
      r = NTS_REG_RDP;
    end else if (a >= `NTS_OFS_STS_FIRST && a <= `NTS_OFS_STS_LAST) begin
      r = NTS_REG_STSRSV;
    end else if (a[15:6] == `NTS_OFS_SUBM_BASE >> 6) begin
      r = NTS_REG_SUBM;
    end else if (a[15:4] == `NTS_OFS_CPL_BASE >> 4) begin
      r = NTS_REG_CPL;
    end else if (a == `NTS_OFS_VERSION) begin
      r = NTS_REG_VER;
    end else if (a == `NTS_OFS_IRQ_STATUS) begin
      r = NTS_REG_ISTS;
    end else if (a == `NTS_OFS_IRQ_MASK) begin
      r = NTS_REG_IMSK;
    end else if (a[15:12] == `NTS_OFS_IDC_BASE >> 12) begin
      r = NTS_REG_IDC;
    end else if (a[15:12] == `NTS_OFS_IDN_BASE >> 12) begin
      r = NTS_REG_IDN;
    end else if (a >= `NTS_OFS_CRAM_BASE && a <= `NTS_OFS_CRAM_LAST) begin
      r = NTS_REG_CRAM;
    end
    return r;
  endfunction

  // byte-lane merge of write data into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic slow_r;
  logic fail_seen_r;
  nts_fail_s fail_r;
  logic [44:0] count_r;
  logic [2:0] irq_sts_r;
  logic [2:0] irq_mask_r;
  logic [2:0] irq_sts_nxt;
  logic [2:0] read_clr_r;
  logic [31:0] idc_mem [0:1023];
  logic [31:0] idn_mem [0:1023];
  logic [31:0] cram_mem [0:2047];
  logic setup;
  logic done;
  logic wr_done;
  nts_region_e region;

  // setup phase samples the read data; the access phase then completes at once
  assign setup = PSEL_I && !PENABLE_I;
  assign done = PSEL_I && PENABLE_I && PREADY_O;
  assign wr_done = done && PWRITE_I;
  assign region = decode(PADDR_I);

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake

  // ready rises for exactly the first access cycle, so no wait states
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else if (setup) begin
      PREADY_O <= 1'b1;
      PSLVERR_O <= (region == NTS_REG_NONE);
    end else begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

  // read mux captured at setup; write-only and unmapped words read zero
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      PRDATA_O <= 32'h0;
      read_clr_r <= 3'h0;
    end else if (setup && !PWRITE_I) begin
      read_clr_r <= 3'h0;
      case (region)
        NTS_REG_FREE: PRDATA_O <= {22'h0, GEN_FREE_COUNT_I};
        NTS_REG_SLOW: PRDATA_O <= {31'h0, slow_r};
        NTS_REG_FAILL: PRDATA_O <= fail_r.addr[31:0];
        NTS_REG_FAILH: PRDATA_O <= {7'h0, fail_r.addr[56:32]};
        NTS_REG_CNTL: PRDATA_O <= count_r[31:0];
        NTS_REG_CNTH: PRDATA_O <= {19'h0, count_r[44:32]};
        NTS_REG_EXP: PRDATA_O <= fail_r.expected[32*PADDR_I[3:2] +: 32];
        NTS_REG_RDP: PRDATA_O <= fail_r.readback[32*PADDR_I[3:2] +: 32];
        NTS_REG_CPL: PRDATA_O <= CPL_ENTRY_I[32*PADDR_I[3:2] +: 32];
        NTS_REG_VER: PRDATA_O <= CORE_VERSION_I;
        NTS_REG_IDC: PRDATA_O <= idc_mem[PADDR_I[11:2]];
        NTS_REG_IDN: PRDATA_O <= idn_mem[PADDR_I[11:2]];
        NTS_REG_CRAM: PRDATA_O <= cram_mem[PADDR_I[12:2]];
        NTS_REG_IMSK: PRDATA_O <= {29'h0, irq_mask_r};
        NTS_REG_ISTS: begin
          PRDATA_O <= {29'h0, irq_sts_r};
          // only the bits shown to software are later cleared
          read_clr_r <= irq_sts_r;
        end
        default: PRDATA_O <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // generator status

  // set wins over the auto-clear so a late event is never lost
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      slow_r <= 1'b0;
    end else if (GEN_SLOW_I) begin
      slow_r <= 1'b1;
    end else if (TEST_START_I) begin
      slow_r <= 1'b0;
    end
  end

  // first miscompare only; a restart rearms the capture
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      fail_seen_r <= 1'b0;
      fail_r <= '0;
    end else if (GEN_FAIL_I && (!fail_seen_r || TEST_START_I)) begin
      fail_seen_r <= 1'b1;
      fail_r <= GEN_FAIL_INFO_I;
    end else if (TEST_START_I) begin
      fail_seen_r <= 1'b0;
    end
  end

  // counter is registered so both halves track the same clock
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      count_r <= 45'h0;
    end else begin
      count_r <= GEN_COMPLETED_COUNT_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // custom submission entry

  // only the submission words take writes; status range writes are dropped
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      SUBM_ENTRY_O <= 512'h0;
    end else if (wr_done && region == NTS_REG_SUBM) begin
      SUBM_ENTRY_O[32*PADDR_I[5:2] +: 32] <=
        merge(SUBM_ENTRY_O[32*PADDR_I[5:2] +: 32], PWDATA_I, PSTRB_I);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memories

  // identify windows are filled by the core only; bus side reads them
  always_ff @(posedge CLOCK_I) begin
    if (IDEN_WR_I.we && !IDEN_WR_I.sel) begin
      idc_mem[IDEN_WR_I.addr] <= IDEN_WR_I.data;
    end
    if (IDEN_WR_I.we && IDEN_WR_I.sel) begin
      idn_mem[IDEN_WR_I.addr] <= IDEN_WR_I.data;
    end
  end

  // shared ram; on a same-word collision the bus write lands last
  always_ff @(posedge CLOCK_I) begin
    if (CRAM_REQ_I.we) begin
      cram_mem[CRAM_REQ_I.addr] <= CRAM_REQ_I.data;
    end
    if (wr_done && region == NTS_REG_CRAM) begin
      cram_mem[PADDR_I[12:2]] <= merge(cram_mem[PADDR_I[12:2]], PWDATA_I, PSTRB_I);
    end
  end

  // core read port, one cycle latency
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      CRAM_RDATA_O <= 32'h0;
    end else begin
      CRAM_RDATA_O <= cram_mem[CRAM_REQ_I.addr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  // sticky events; a read clears what it returned, new events win
  always_comb begin
    irq_sts_nxt = irq_sts_r;
    if (done && !PWRITE_I && region == NTS_REG_ISTS) begin
      irq_sts_nxt = irq_sts_nxt & ~read_clr_r;
    end
    irq_sts_nxt[`NTS_IRQ_BIT_SLOW] = irq_sts_nxt[`NTS_IRQ_BIT_SLOW] | GEN_SLOW_I;
    irq_sts_nxt[`NTS_IRQ_BIT_FAIL] = irq_sts_nxt[`NTS_IRQ_BIT_FAIL] |
                                     (GEN_FAIL_I && (!fail_seen_r || TEST_START_I));
    irq_sts_nxt[`NTS_IRQ_BIT_CPL] = irq_sts_nxt[`NTS_IRQ_BIT_CPL] | CPL_VALID_I;
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      irq_sts_r <= `NTS_IRQ_RESET;
    end else begin
      irq_sts_r <= irq_sts_nxt;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      irq_mask_r <= `NTS_MASK_RESET;
    end else if (wr_done && region == NTS_REG_IMSK && PSTRB_I[0]) begin
      irq_mask_r <= PWDATA_I[2:0];
    end
  end

  // output registered from the next state so it tracks the status bits
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_sts_nxt & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_free_count_read: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    done && !PWRITE_I && PADDR_I == `NTS_OFS_FREE_COUNT |->
      PRDATA_O == {22'h0, $past(GEN_FREE_COUNT_I)})
    else $error("free count read mismatch");

  a_slow_flag_set: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    GEN_SLOW_I |=> slow_r ##1 (slow_r || $past(TEST_START_I)))
    else $error("slow flag not set");

  a_slow_auto_clear: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    TEST_START_I && !GEN_SLOW_I |=> !slow_r)
    else $error("slow flag not cleared by start");

  a_fail_first_capture: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    GEN_FAIL_I && !fail_seen_r |=>
      fail_r.addr == $past(GEN_FAIL_INFO_I.addr) && fail_seen_r)
    else $error("first fail address not captured");

  a_fail_held: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    fail_seen_r && !TEST_START_I |=> $stable(fail_r))
    else $error("fail capture changed before restart");

  a_count_high_read: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    done && !PWRITE_I && PADDR_I == `NTS_OFS_COUNT_HIGH |->
      PRDATA_O == {19'h0, $past(count_r[44:32])})
    else $error("completed count high read mismatch");

  a_exp_word_read: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    done && !PWRITE_I && PADDR_I == `NTS_OFS_EXP_BASE |->
      PRDATA_O == $past(fail_r.expected[31:0]))
    else $error("expected word0 read mismatch");

  a_rdp_word_read: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    done && !PWRITE_I && PADDR_I == (`NTS_OFS_RDP_BASE + 16'h000c) |->
      PRDATA_O == $past(fail_r.readback[127:96]))
    else $error("read word3 read mismatch");

  a_status_ro_write: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    wr_done && PADDR_I >= `NTS_OFS_STS_FIRST && PADDR_I <= `NTS_OFS_STS_LAST |=>
      $stable(SUBM_ENTRY_O) && $stable(irq_mask_r))
    else $error("write to status range changed state");

  a_subm_word_write: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    wr_done && region == NTS_REG_SUBM && PSTRB_I == 4'hf |=>
      SUBM_ENTRY_O[32*$past(PADDR_I[5:2]) +: 32] == $past(PWDATA_I))
    else $error("submission word not written");

  a_version_read: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    done && !PWRITE_I && PADDR_I == `NTS_OFS_VERSION |->
      PRDATA_O == $past(CORE_VERSION_I) && !PSLVERR_O)
    else $error("version read mismatch");

  a_cpl_word_read: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    done && !PWRITE_I && region == NTS_REG_CPL |->
      PRDATA_O == $past(CPL_ENTRY_I[32*PADDR_I[3:2] +: 32]))
    else $error("completion word read mismatch");

endmodule

`default_nettype wire

// ### testbench/nts_far_model.sv
// far-side model: test generator and controller core facing the status bank
// assumes the bank's clock; the bench drives it through the tasks below
`timescale 1ns/100ps
`default_nettype none

module nts_far_model
  import nts_pkg::*;
(
  input wire logic clk_i,
  output logic [9:0] free_o,
  output logic slow_o,
  output logic start_o,
  output logic fail_o,
  output var nts_fail_s fail_info_o,
  output logic [44:0] count_o,
  output logic [31:0] ver_o,
  output logic [127:0] cpl_o,
  output logic cpl_valid_o,
  output var nts_iden_wr_s iden_o,
  output var nts_ram_req_s ram_o,
  input wire logic [31:0] ram_rdata_i
);
  ////////////////////////////////////////////////////////////////////////////
  // idle values until the bench sets live ones
  initial begin
    {free_o, slow_o, start_o, fail_o, fail_info_o, count_o} = '0;
    {ver_o, cpl_o, cpl_valid_o, iden_o, ram_o} = '0;
  end

  // live status words, changed just after an edge
  task automatic set_live(input logic [9:0] f, input logic [44:0] c, input logic [31:0] v,
                          input logic [127:0] e);
    @(posedge clk_i);
    free_o <= f;
    count_o <= c;
    ver_o <= v;
    cpl_o <= e;
  endtask

  // one-cycle strobes: bit 0 slow, 1 start, 2 fail, 3 completion
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_i);
    {cpl_valid_o, fail_o, start_o, slow_o} <= m;
    @(posedge clk_i);
    {cpl_valid_o, fail_o, start_o, slow_o} <= 4'h0;
  endtask

  // only the write and read codes start the generator
  task automatic command(input logic [2:0] code);
    pulse({2'b00, code == 3'b010 || code == 3'b011, 1'b0});
  endtask

  // report is scrambled after the strobe, no stale value to lean on
  task automatic miscompare(input nts_fail_s f);
    fail_info_o <= f;
    pulse(4'h4);
    fail_info_o <= ~f;
  endtask

  // identify capture from the drive, sel 1 for namespace
  task automatic iden_write(input logic sel, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    iden_o <= '{1'b1, sel, a, d};
    @(posedge clk_i);
    iden_o <= '{1'b0, ~sel, ~a, ~d};
  endtask

  // custom ram port, read data one cycle after the address
  task automatic ram_access(input logic we, input logic [10:0] a, input logic [31:0] d,
                            output logic [31:0] q);
    @(posedge clk_i);
    ram_o <= '{we, a, d};
    @(posedge clk_i);
    ram_o <= '{1'b0, ~a, ~d};
    @(negedge clk_i);
    q = ram_rdata_i;
  endtask
endmodule

`default_nettype wire

// ### testbench/test_nvme_test_status_regs.sv
// bench for the test status register bank: apb reads and writes plus far-side events
// assumes nts_pkg compiled first and the far-side model beside this file
`timescale 1ns/100ps
`default_nettype none
`define NTS_CHK(name, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("wrong value %s expected %h seen %h", name, exp, got); \
    end \
  end

module test_nvme_test_status_regs
  import nts_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata, rdat, q, ver, cram_rd;
  logic pready, pslverr, irq, rerr, slow, start, fail, cplv;
  logic [9:0] free;
  logic [44:0] count;
  logic [127:0] cple;
  logic [127:0] ce = 128'h3333_0003_2222_0002_1111_0001_0000_0000;
  logic [511:0] subm;
  nts_fail_s finfo, f1, f2;
  nts_iden_wr_s iden;
  nts_ram_req_s ram;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;

  nts_regs i_dut (
    .CLOCK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq),
    .GEN_FREE_COUNT_I(free), .GEN_SLOW_I(slow), .TEST_START_I(start), .GEN_FAIL_I(fail),
    .GEN_FAIL_INFO_I(finfo), .GEN_COMPLETED_COUNT_I(count), .CORE_VERSION_I(ver),
    .CPL_ENTRY_I(cple), .CPL_VALID_I(cplv), .SUBM_ENTRY_O(subm), .IDEN_WR_I(iden),
    .CRAM_REQ_I(ram), .CRAM_RDATA_O(cram_rd)
  );

  nts_far_model i_far (
    .clk_i(clk), .free_o(free), .slow_o(slow), .start_o(start), .fail_o(fail),
    .fail_info_o(finfo), .count_o(count), .ver_o(ver), .cpl_o(cple), .cpl_valid_o(cplv),
    .iden_o(iden), .ram_o(ram), .ram_rdata_i(cram_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 200 mhz clock
  always #2.5 clk = ~clk;

  // hang guard, the whole run needs under two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic ee = 1'b0);
    xfer(1'b0, a, 32'h0, 4'h0);
    `NTS_CHK($sformatf("data at %h", a), e, rdat)
    `NTS_CHK($sformatf("error at %h", a), ee, rerr)
  endtask

  // byte enables default to a full word; partial lanes exercise the merge
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic ee = 1'b0,
                    input logic [3:0] s = 4'hf);
    xfer(1'b1, a, d, s);
    `NTS_CHK($sformatf("write error at %h", a), ee, rerr)
  endtask

  // irq is registered, so let two edges land first
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `NTS_CHK("irq", e, irq)
  endtask

  task automatic chk_fail(input nts_fail_s f);
    rd(16'h0140, f.addr[31:0]);
    rd(16'h0144, {7'h00, f.addr[56:32]});
    for (int k = 0; k < 4; k++) begin
      rd(16'h0180 + 16'(4 * k), f.expected[32 * k +: 32]);
      rd(16'h01c0 + 16'(4 * k), f.readback[32 * k +: 32]);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    f1 = {57'h1abcdef01234567, 128'h4444_4444_3333_3333_2222_2222_1111_1111,
          128'h8888_8888_7777_7777_6666_6666_5555_5555};
    f2 = ~f1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(16'h0128, 32'h0);
    `NTS_CHK("subm", 512'h0, subm)
    `NTS_CHK("irq", 1'b0, irq)
    // live mirrors, boundary free count included
    i_far.set_live(10'h2a5, 45'h1abc_1234_5678, 32'h0a0b_0c0d, ce);
    rd(16'h0124, 32'h0000_02a5);
    rd(16'h0148, 32'h1234_5678);
    rd(16'h014c, 32'h0000_1abc);
    rd(16'h0800, 32'h0a0b_0c0d);
    for (int k = 0; k < 4; k++) rd(16'h0300 + 16'(4 * k), ce[32 * k +: 32]);
    i_far.set_live(10'h3ff, 45'h0, 32'h0, ce);
    rd(16'h0124, 32'h0000_03ff);
    $display("live mirror test done");
    // slow flag set and auto-clear, set wins over start
    i_far.pulse(4'h1);
    rd(16'h0128, 32'h1);
    i_far.command(3'b010);
    rd(16'h0128, 32'h0);
    i_far.pulse(4'h1);
    i_far.command(3'b100);
    rd(16'h0128, 32'h1);
    i_far.command(3'b011);
    rd(16'h0128, 32'h0);
    i_far.pulse(4'h3);
    rd(16'h0128, 32'h1);
    $display("slow flag test done");
    // first miscompare kept until restart
    i_far.command(3'b011);
    i_far.miscompare(f1);
    chk_fail(f1);
    i_far.miscompare(f2);
    chk_fail(f1);
    i_far.command(3'b010);
    i_far.miscompare(f2);
    chk_fail(f2);
    $display("fail capture test done");
    // status range ignores writes
    wr(16'h0140, 32'hffff_ffff);
    wr(16'h0128, 32'h1);
    wr(16'h01fc, 32'h1);
    rd(16'h0128, 32'h0);
    rd(16'h01fc, 32'h0);
    chk_fail(f2);
    $display("read-only test done");
    // submission dwords in order, not readable
    for (int k = 0; k < 16; k++) wr(16'h0200 + 16'(4 * k), 32'h5a00_0000 + 32'(k));
    @(negedge clk);
    for (int k = 0; k < 16; k++) begin
      `NTS_CHK("subm dword", 32'h5a00_0000 + 32'(k), subm[32 * k +: 32])
    end
    rd(16'h0200, 32'h0);
    // one byte lane only, the rest of the dword must survive
    wr(16'h0204, 32'hffff_ffff, 1'b0, 4'h2);
    @(negedge clk);
    `NTS_CHK("subm strobe", 32'h5a00_ff01, subm[63:32])
    $display("submission test done");
    // identify windows, first and last controller words and namespace word 5
    i_far.iden_write(1'b0, 10'h000, 32'h1357_9bdf);
    i_far.iden_write(1'b0, 10'h3ff, 32'h2468_ace0);
    i_far.iden_write(1'b1, 10'h005, 32'hfeed_0005);
    rd(16'h2000, 32'h1357_9bdf);
    rd(16'h2ffc, 32'h2468_ace0);
    rd(16'h3014, 32'hfeed_0005);
    // custom ram from both sides
    wr(16'h4008, 32'hc0de_0002);
    i_far.ram_access(1'b0, 11'h002, 32'h0, q);
    `NTS_CHK("ram port", 32'hc0de_0002, q)
    i_far.ram_access(1'b1, 11'h7ff, 32'h0bad_f00d, q);
    rd(16'h5ffc, 32'h0bad_f00d);
    wr(16'h4008, 32'hffff_ffff, 1'b0, 4'h8);
    rd(16'h4008, 32'hffde_0002);
    $display("window test done");
    // interrupt: read-to-clear status and mask
    rd(16'h0900, 32'h0000_0003);
    wr(16'h0904, 32'h1);
    i_far.pulse(4'h8);
    irq_is(1'b0);
    rd(16'h0900, 32'h0000_0004);
    i_far.pulse(4'h1);
    irq_is(1'b1);
    rd(16'h0900, 32'h0000_0001);
    irq_is(1'b0);
    wr(16'h0904, 32'h6, 1'b0, 4'h0);
    rd(16'h0904, 32'h0000_0001);
    // unmapped and misaligned
    rd(16'h0a00, 32'h0, 1'b1);
    rd(16'h0126, 32'h0, 1'b1);
    wr(16'h0a00, 32'h1, 1'b1);
    $display("interrupt and error test done");
    // mid-run reset returns the bank to its idle values
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(16'h0904, 32'h0);
    rd(16'h0140, 32'h0);
    `NTS_CHK("subm after reset", 512'h0, subm)
    $display("reset test done");
    end_of_test();
  end
endmodule

`default_nettype wire
